// *** hdl/asp_pkg.sv ***
package asp_pkg;
    // assumed core rates for the divider
    localparam int SYSCLK_5_HZ = 5000000;
    localparam int SYSCLK_10_HZ = 10000000;
    localparam int SYSCLK_20_HZ = 20000000;
    localparam int OVERSAMPLE = 16;
    localparam int BAUD_SLOWEST = 600;
    localparam logic [11:0] DIV_5 = 12'(SYSCLK_5_HZ / (OVERSAMPLE * BAUD_SLOWEST));
    localparam logic [11:0] DIV_10 = 12'(SYSCLK_10_HZ / (OVERSAMPLE * BAUD_SLOWEST));
    localparam logic [11:0] DIV_20 = 12'(SYSCLK_20_HZ / (OVERSAMPLE * BAUD_SLOWEST));
    // configuration register indices
    localparam logic [7:0] CFG_CLK_IDX = 8'h13;
    localparam logic [7:0] CFG_FMT_IDX = 8'h14;
    localparam logic [7:0] CFG_FMT_RST = 8'h00;
    localparam logic [7:0] CFG_CLK_RST = 8'h00;
    // format register fields
    localparam int FMT_TX_EN = 0;
    localparam int FMT_RX_EN = 1;
    localparam int FMT_M_LO = 2;
    localparam int FMT_NINTH = 4;
    localparam int FMT_BR_LO = 5;
    // clock register fields
    localparam int CLK_SEL_LO = 1;
    localparam int CLK_IRQ_LO = 3;
    localparam logic [1:0] SYSCLK_10M = 2'h1;
    localparam logic [1:0] SYSCLK_20M = 2'h2;
    localparam logic [2:0] BAUD_UNUSED = 3'h7;
    // character layouts
    localparam logic [1:0] LAYOUT_1STOP = 2'h0;
    localparam logic [1:0] LAYOUT_2STOP = 2'h1;
    localparam logic [1:0] LAYOUT_PARITY = 2'h2;
    localparam logic [1:0] LAYOUT_NINE = 2'h3;
    // receive sampling
    localparam logic [3:0] SAMPLE_A = 4'h7;
    localparam logic [3:0] SAMPLE_B = 4'h8;
    localparam logic [3:0] SAMPLE_C = 4'h9;
    localparam logic [3:0] SAMPLE_LAST = 4'hf;
    localparam logic [2:0] IDLE_HIGHS = 3'h7;
    localparam logic [3:0] STEPS_SHORT = 4'h9;
    localparam logic [3:0] STEPS_LONG = 4'ha;
    localparam logic [3:0] BREAK_BITS = 4'ha;
    // transmit frame: index of the trailing idle bit
    localparam logic [3:0] TX_GAP_SHORT = 4'ha;
    localparam logic [3:0] TX_GAP_LONG = 4'hb;
    // status register bits
    localparam int ST_RX_FULL = 0;
    localparam int ST_OVERRUN = 1;
    localparam int ST_FRM = 2;
    localparam int ST_NSE = 3;
    localparam int ST_TX_EMPTY = 4;
    localparam int ST_TX_DONE = 5;
    localparam int ST_BREAK = 6;
    localparam int ST_RX9 = 7;
    typedef enum logic {RX_IDLE = 1'b0, RX_RUN = 1'b1} asp_rx_state_t;
    typedef enum logic {TX_IDLE = 1'b0, TX_SHIFT = 1'b1} asp_tx_state_t;
endpackage

// *** hdl/asp_fifo.sv ***
`timescale 1ns/1ps
module asp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("asp_fifo depth must be a power of two");
    end
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = !(wr_q[AW] != rd_q[AW] && wr_q[AW-1:0] == rd_q[AW-1:0]);
    assign out_valid = wr_q != rd_q;
    assign out_data = mem_q[rd_q[AW-1:0]];
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) wr_q <= wr_q + 1'b1;
            if (pop) rd_q <= rd_q + 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (push) mem_q[wr_q[AW-1:0]] <= in_data;
    end
endmodule

// *** hdl/asp_uart.sv ***
`timescale 1ns/1ps
module asp_uart
    import asp_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic cfg_wr,
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    output logic [7:0] cfg_format,
    output logic [7:0] cfg_clock,
    input wire logic tx_wr,
    input wire logic [7:0] tx_wdata,
    output logic tx_wr_ready,
    input wire logic rx_rd,
    output logic [7:0] rx_data,
    output logic [7:0] status,
    output logic irq,
    input wire logic serial_in_pin,
    output logic serial_out_pin
);
    if (FIFO_DEPTH < 2) begin : g_bad_fifo
        $error("asp_uart fifo depth too small");
    end

    function automatic logic [11:0] base_div(input logic [1:0] sel);
        case (sel)
            SYSCLK_10M: base_div = DIV_10;
            SYSCLK_20M: base_div = DIV_20;
            default: base_div = DIV_5;
        endcase
    endfunction

    function automatic logic maj3(input logic a, input logic b, input logic c);
        maj3 = (a & b) | (a & c) | (b & c);
    endfunction

    // odd when sel low, even when sel high
    function automatic logic par_bit(input logic [7:0] d, input logic sel);
        par_bit = ^d ^ ~sel;
    endfunction

    // configuration registers
    logic [7:0] fmt_q;
    logic [7:0] clk_cfg_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fmt_q <= CFG_FMT_RST;
            clk_cfg_q <= CFG_CLK_RST;
        end else if (cfg_wr && cfg_addr == CFG_FMT_IDX) begin
            fmt_q <= cfg_wdata;
        end else if (cfg_wr && cfg_addr == CFG_CLK_IDX) begin
            clk_cfg_q <= cfg_wdata;
        end
    end
    assign cfg_format = fmt_q;
    assign cfg_clock = clk_cfg_q;

    wire tx_enable = fmt_q[FMT_TX_EN];
    wire rx_enable = fmt_q[FMT_RX_EN];
    wire [1:0] layout = fmt_q[FMT_M_LO +: 2];
    wire ninth_bit_or_parity_sel = fmt_q[FMT_NINTH];
    wire [2:0] baud_select = fmt_q[FMT_BR_LO +: 3];
    wire [1:0] sysclk_select = clk_cfg_q[CLK_SEL_LO +: 2];
    wire [4:0] irq_en = clk_cfg_q[CLK_IRQ_LO +: 5];

    // baud generator
    wire baud_off = baud_select == BAUD_UNUSED;
    wire [11:0] baud_div = base_div(sysclk_select) >> baud_select;
    logic [11:0] div_q;
    logic [3:0] sub_q;
    wire samp_tick = !baud_off && div_q == '0;
    wire tx_tick = samp_tick && sub_q == SAMPLE_LAST;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_q <= '0;
            sub_q <= '0;
        end else if (baud_off) begin
            div_q <= '0;
        end else if (samp_tick) begin
            div_q <= baud_div - 1'b1;
            sub_q <= sub_q + 1'b1;
        end else begin
            div_q <= div_q - 1'b1;
        end
    end

    // receiver
    asp_rx_state_t rx_state_q;
    logic [2:0] hist_q;
    logic [3:0] rx_phase_q;
    logic [3:0] rx_idx_q;
    logic [9:0] rx_bits_q;
    logic vote_a_q;
    logic vote_b_q;
    logic noise_acc_q;
    logic [3:0] zero_run_q;
    logic rx_fin_q;
    wire [3:0] rx_steps = (layout == LAYOUT_1STOP) ? STEPS_SHORT : STEPS_LONG;
    wire start_hit = samp_tick && rx_state_q == RX_IDLE && hist_q == IDLE_HIGHS
        && !serial_in_pin;
    wire vote_tick = samp_tick && rx_state_q == RX_RUN && rx_phase_q == SAMPLE_C;
    wire bit_v = maj3(vote_a_q, vote_b_q, serial_in_pin);
    wire noisy = (vote_a_q != vote_b_q) || (vote_b_q != serial_in_pin);
    wire false_start = vote_tick && rx_idx_q == '0 && bit_v;
    wire rx_last = vote_tick && !false_start && rx_idx_q == rx_steps;
    wire brk_ev = vote_tick && !bit_v && zero_run_q == BREAK_BITS - 1'b1;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hist_q <= '0;
            vote_a_q <= 1'b0;
            vote_b_q <= 1'b0;
        end else if (!rx_enable || rx_last) begin
            hist_q <= '0;
        end else if (samp_tick) begin
            hist_q <= {hist_q[1:0], serial_in_pin};
            if (rx_phase_q == SAMPLE_A) vote_a_q <= serial_in_pin;
            if (rx_phase_q == SAMPLE_B) vote_b_q <= serial_in_pin;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_state_q <= RX_IDLE;
            rx_phase_q <= '0;
        end else if (!rx_enable) begin
            rx_state_q <= RX_IDLE;
        end else if (start_hit) begin
            rx_state_q <= RX_RUN;
            rx_phase_q <= '0;
        end else if (samp_tick && rx_state_q == RX_RUN) begin
            rx_phase_q <= rx_phase_q + 1'b1;
            // noise alone never ends the character
            if (false_start || rx_last) rx_state_q <= RX_IDLE;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_idx_q <= '0;
            rx_bits_q <= '0;
            noise_acc_q <= 1'b0;
            zero_run_q <= '0;
        end else if (start_hit) begin
            rx_idx_q <= '0;
            noise_acc_q <= 1'b0;
            zero_run_q <= '0;
        end else if (vote_tick) begin
            noise_acc_q <= noise_acc_q | noisy;
            zero_run_q <= bit_v ? 4'h0 : zero_run_q + 1'b1;
            if (rx_idx_q != '0) rx_bits_q[rx_idx_q - 1'b1] <= bit_v;
            rx_idx_q <= rx_idx_q + 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) rx_fin_q <= 1'b0;
        else rx_fin_q <= rx_enable && rx_last;
    end

    // end-of-character checks
    logic stop_ok;
    always_comb begin
        case (layout)
            LAYOUT_1STOP: stop_ok = rx_bits_q[8];
            LAYOUT_2STOP: stop_ok = rx_bits_q[8] & rx_bits_q[9];
            default: stop_ok = rx_bits_q[9];
        endcase
    end
    wire par_bad = layout == LAYOUT_PARITY
        && rx_bits_q[8] != par_bit(rx_bits_q[7:0], ninth_bit_or_parity_sel);
    wire frame_err = !stop_ok || par_bad;
    wire rx_ninth = layout == LAYOUT_NINE && rx_bits_q[8];

    // receive holding buffer
    logic [7:0] rx_data_q;
    logic rx_full_q;
    logic overrun_q;
    logic framing_q;
    logic noise_q;
    logic ninth_q;
    logic break_q;
    wire rx_load = rx_fin_q && (!rx_full_q || rx_rd);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_data_q <= '0;
            framing_q <= 1'b0;
            noise_q <= 1'b0;
            ninth_q <= 1'b0;
        end else if (rx_load) begin
            rx_data_q <= rx_bits_q[7:0];
            framing_q <= frame_err;
            noise_q <= noise_acc_q;
            ninth_q <= rx_ninth;
        end
    end
    // new events win over a clearing read
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_full_q <= 1'b0;
            overrun_q <= 1'b0;
            break_q <= 1'b0;
        end else begin
            if (rx_load) rx_full_q <= 1'b1;
            else if (rx_rd) rx_full_q <= 1'b0;
            if (rx_fin_q && rx_full_q && !rx_rd) overrun_q <= 1'b1;
            else if (rx_rd) overrun_q <= 1'b0;
            if (brk_ev) break_q <= 1'b1;
            else if (rx_rd) break_q <= 1'b0;
        end
    end
    assign rx_data = rx_data_q;

    // transmit path: fifo feeds the holding stage
    logic [7:0] hold_q;
    logic hold_full_q;
    logic fifo_valid;
    logic [7:0] fifo_data;
    wire fifo_take = !hold_full_q && tx_enable;
    asp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) i_asp_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(tx_wr && tx_enable),
        .in_ready(tx_wr_ready),
        .in_data(tx_wdata),
        .out_valid(fifo_valid),
        .out_ready(fifo_take),
        .out_data(fifo_data)
    );
    wire tx_empty = !hold_full_q && !fifo_valid;

    asp_tx_state_t tx_state_q;
    logic [11:0] tx_shift_q;
    logic [3:0] tx_bit_q;
    logic tx_done_q;
    wire [3:0] tx_gap_idx = (layout == LAYOUT_1STOP) ? TX_GAP_SHORT : TX_GAP_LONG;
    wire tx_extra = (layout == LAYOUT_PARITY) ? par_bit(hold_q, ninth_bit_or_parity_sel)
        : (layout == LAYOUT_NINE) ? ninth_bit_or_parity_sel : 1'b1;
    wire [11:0] tx_frame = {2'b11, tx_extra, hold_q, 1'b0};
    // reload only after the idle bit has gone out
    wire tx_ld = tx_tick && hold_full_q && tx_enable
        && (tx_state_q == TX_IDLE || tx_bit_q == tx_gap_idx);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hold_q <= '0;
            hold_full_q <= 1'b0;
        end else if (fifo_take && fifo_valid) begin
            hold_q <= fifo_data;
            hold_full_q <= 1'b1;
        end else if (tx_ld) begin
            hold_full_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_state_q <= TX_IDLE;
            tx_shift_q <= '1;
            tx_bit_q <= '0;
            tx_done_q <= 1'b1;
        end else if (tx_ld) begin
            tx_state_q <= TX_SHIFT;
            tx_shift_q <= tx_frame;
            tx_bit_q <= '0;
            tx_done_q <= 1'b0;
        end else if (tx_tick && tx_state_q == TX_SHIFT) begin
            tx_shift_q <= {1'b1, tx_shift_q[11:1]};
            if (tx_bit_q == tx_gap_idx) tx_state_q <= TX_IDLE;
            else tx_bit_q <= tx_bit_q + 1'b1;
            if (tx_bit_q == tx_gap_idx - 1'b1) tx_done_q <= 1'b1;
        end
    end
    assign serial_out_pin = tx_shift_q[0];

    // status and interrupt request
    always_comb begin
        status = '0;
        status[ST_RX_FULL] = rx_full_q;
        status[ST_OVERRUN] = overrun_q;
        status[ST_FRM] = framing_q;
        status[ST_NSE] = noise_q;
        status[ST_TX_EMPTY] = tx_empty;
        status[ST_TX_DONE] = tx_done_q;
        status[ST_BREAK] = break_q;
        status[ST_RX9] = ninth_q;
    end
    assign irq = |(irq_en & {rx_full_q, overrun_q, break_q, tx_empty, tx_done_q});

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_char_kept;
        rx_fin_q && !rx_full_q;
    endsequence

    sequence s_char_lost;
        rx_fin_q && rx_full_q && !rx_rd;
    endsequence

    sequence s_tx_load;
        tx_ld;
    endsequence

    rx_start_seen_a: assert property ($rose(rx_state_q == RX_RUN) |->
        $past(hist_q) == IDLE_HIGHS && !$past(serial_in_pin))
        else $error("receiver started without three high samples");

    rx_phase_step_a: assert property (samp_tick && rx_state_q == RX_RUN
        && !false_start && !rx_last |=> rx_phase_q == 4'($past(rx_phase_q) + 1'b1))
        else $error("sample phase did not advance by one");

    rx_step_count_a: assert property (rx_fin_q |->
        $past(rx_idx_q) == $past(rx_steps))
        else $error("character ended on the wrong bit step");

    rx_noise_kept_a: assert property (s_char_kept ##0 noise_acc_q |=>
        noise_q && rx_full_q)
        else $error("noisy character not flagged");

    rx_frame_flag_a: assert property (s_char_kept |=> framing_q == $past(frame_err))
        else $error("framing flag does not match end checks");

    rx_load_word_a: assert property (s_char_kept |=>
        rx_full_q && rx_data == $past(rx_bits_q[7:0]))
        else $error("holding buffer not loaded");

    rx_overrun_keep_a: assert property (s_char_lost |=>
        overrun_q && rx_full_q && $stable(rx_data))
        else $error("overrun mishandled");

    rx_read_clear_a: assert property (rx_rd && !rx_fin_q |=> !rx_full_q)
        else $error("read did not empty the buffer");

    rx_break_irq_a: assert property (brk_ev && irq_en[2] |=> break_q && irq)
        else $error("break not raised");

    rx_disabled_a: assert property (!rx_enable |=> rx_state_q == RX_IDLE)
        else $error("receiver runs while disabled");

    tx_load_start_a: assert property (s_tx_load |=>
        !tx_done_q && !serial_out_pin && tx_state_q == TX_SHIFT)
        else $error("load did not start a character");

    tx_idle_hold_a: assert property (!tx_enable && tx_state_q == TX_IDLE
        |=> tx_state_q == TX_IDLE && $stable(hold_full_q))
        else $error("transmitter moved while disabled");

    tx_fill_flag_a: assert property (tx_wr && tx_enable && tx_wr_ready
        |=> !tx_empty)
        else $error("empty flag stayed set after write");

    tx_gap_bit_a: assert property (tx_state_q == TX_SHIFT
        && tx_bit_q == tx_gap_idx |-> serial_out_pin && tx_done_q)
        else $error("no idle bit after stop");

    tx_finish_a: assert property ($fell(tx_enable) && tx_state_q == TX_SHIFT
        |=> tx_state_q == TX_SHIFT)
        else $error("character cut short on disable");
endmodule

// *** verif/asp_far_end.sv ***
`timescale 1ns/1ps
module asp_far_end #(
    parameter int BIT_NS = 2560
) (
    input wire logic tx_line,
    output logic rx_line
);
    longint t0;
    initial rx_line = 1'b1;
    // idle gap first, then lsb first; bit g gets a one-sample glitch mid-bit
    task automatic send(input logic [11:0] f, input int n, input int g);
        rx_line = 1'b1;
        #(2 * BIT_NS);
        for (int i = 0; i < n; i++) begin
            rx_line = f[i];
            if (i == g) begin
                #(BIT_NS / 2);
                rx_line = ~f[i];
                #(BIT_NS / 16);
                rx_line = f[i];
                #(BIT_NS * 7 / 16);
            end else begin
                #(BIT_NS);
            end
        end
        rx_line = 1'b1;
    endtask
    // samples each bit at its middle
    task automatic grab(output logic [11:0] f, input int n);
        f = 12'hfff;
        @(negedge tx_line);
        t0 = $time;
        #(BIT_NS / 2);
        for (int i = 0; i < n; i++) begin
            f[i] = tx_line;
            #(BIT_NS);
        end
    endtask
endmodule

// *** verif/tb_asp_uart.sv ***
`timescale 1ns/1ps
module tb_asp_uart;
    import asp_pkg::*;
    localparam int BIT_NS = 2560;
    logic clk, rst, cfg_wr, tx_wr, rx_rd, tx_wr_ready, irq, sin, sout, x;
    logic [7:0] cfg_addr, cfg_wdata, tx_wdata, cfg_format, cfg_clock, rx_data, status, d, e;
    logic [11:0] f;
    logic [7:0] q[$];
    longint tp;
    int num_errors = 0;
    int check_count = 0;
    int seed = 73;
    int k;

    asp_uart #(.FIFO_DEPTH(2)) i_asp_uart (.clk(clk), .rst(rst), .cfg_wr(cfg_wr),
        .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_format(cfg_format),
        .cfg_clock(cfg_clock), .tx_wr(tx_wr), .tx_wdata(tx_wdata),
        .tx_wr_ready(tx_wr_ready), .rx_rd(rx_rd), .rx_data(rx_data), .status(status),
        .irq(irq), .serial_in_pin(sin), .serial_out_pin(sout));
    asp_far_end #(.BIT_NS(BIT_NS)) i_asp_far_end (.tx_line(sout), .rx_line(sin));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    function automatic logic [11:0] fr(input logic [7:0] dd, input logic [1:0] lay,
                                       input logic t8);
        logic b9;
        b9 = (lay == LAYOUT_PARITY) ? (t8 ? ^dd : ~^dd) : (lay == LAYOUT_NINE) ? t8 : 1'b1;
        return {2'h3, b9, dd, 1'b0};
    endfunction
    function automatic int nb(input logic [1:0] lay);
        return (lay == LAYOUT_1STOP) ? 10 : 11;
    endfunction
    function automatic logic [7:0] fmt(input logic [1:0] lay, input logic t8,
                                       input logic tx_on, input logic rx_on);
        return {3'h6, t8, lay, rx_on, tx_on};
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string nm);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic cfg(input logic [7:0] a, input logic [7:0] v);
        cfg_addr = a;
        cfg_wdata = v;
        cfg_wr = 1'b1;
        tick(1);
        cfg_wr = 1'b0;
        tick(1);
    endtask
    task automatic wr(input logic [7:0] v);
        tx_wdata = v;
        tx_wr = 1'b1;
        tick(1);
        tx_wr = 1'b0;
        tick(1);
    endtask
    task automatic rd();
        rx_rd = 1'b1;
        tick(1);
        rx_rd = 1'b0;
        tick(1);
    endtask
    task automatic wait_rx();
        for (int i = 0; i < 900 && status[0] !== 1'b1; i++) tick(1);
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        #550000;
        num_errors++;
        finish_test();
    end

    initial begin
        {rst, cfg_wr, tx_wr, rx_rd, cfg_addr, cfg_wdata, tx_wdata} = {4'h8, 24'h0};
        tick(10);
        rst = 1'b0;
        cmp({status, cfg_format, cfg_clock, rx_data}, 32'h30000000, "reset_regs");
        cmp({sout, tx_wr_ready, irq}, 3'h6, "reset_pins");
        cfg(CFG_CLK_IDX, 8'h84);
        cfg(CFG_FMT_IDX, fmt(LAYOUT_1STOP, 1'b0, 1'b0, 1'b0));
        cfg(8'h15, 8'hff);
        cmp({cfg_clock, cfg_format}, 16'h84c0, "cfg_readback");
        // both directions disabled: write dropped, frame ignored
        wr(8'h5a);
        cmp(status[4], 1, "tx_empty_off");
        i_asp_far_end.send(fr(8'h3c, LAYOUT_1STOP, 1'b0), 10, -1);
        tick(40);
        cmp({status[0], sout}, 2'h1, "disabled");
        for (int lay = 0; lay < 4; lay++) begin
            {x, d, e} = 17'($random(seed));
            cfg(CFG_FMT_IDX, fmt(2'(lay), x, 1'b1, 1'b1));
            fork
                begin
                    i_asp_far_end.send(fr(e, 2'(lay), x), nb(2'(lay)), -1);
                    wait_rx();
                    cmp(rx_data, e, "rx_data");
                    cmp({status[7], status[3:0]}, {lay == 3 && x, 4'h1}, "rx_status");
                    cmp(irq, 1, "irq_full");
                    rd();
                    cmp({irq, status[0]}, 0, "rx_read");
                end
                begin
                    q.delete();
                    k = 0;
                    cmp(status[4], 1, "tx_empty");
                    while (tx_wr_ready === 1'b1 && k < (lay == 0 ? 8 : 1)) begin
                        q.push_back(d + 8'(k));
                        wr(q[k]);
                        cmp(status[4], 0, "tx_full");
                        k++;
                    end
                    if (lay == 0) begin
                        cmp({k > 2, tx_wr_ready}, 2'h2, "fifo_fill");
                        wr(8'hff);
                    end
                    foreach (q[i]) begin
                        tp = i_asp_far_end.t0;
                        i_asp_far_end.grab(f, nb(2'(lay)));
                        cmp(f, fr(q[i], 2'(lay), x), "tx_frame");
                        if (i > 0) cmp(i_asp_far_end.t0 - tp, (nb(2'(lay)) + 1) * BIT_NS, "tx_gap");
                        cmp(status[5], 1, "tx_done");
                    end
                end
                begin
                    if (lay == 3) begin
                        wait (sout === 1'b0);
                        tick(1);
                        cmp(status[5], 0, "tx_busy");
                        cfg(CFG_FMT_IDX, fmt(LAYOUT_NINE, x, 1'b0, 1'b1));
                    end
                end
            join
        end
        cfg(CFG_FMT_IDX, fmt(LAYOUT_1STOP, 1'b0, 1'b0, 1'b1));
        {x, d, e} = 17'($random(seed));
        i_asp_far_end.send(fr(d, LAYOUT_1STOP, 1'b0), 10, 3);
        wait_rx();
        cmp({rx_data, status[3:0]}, {d, 4'h9}, "noise");
        rd();
        // bad stop, then bad parity
        for (int j = 0; j < 2; j++) begin
            cfg(CFG_FMT_IDX, fmt(j ? LAYOUT_PARITY : LAYOUT_1STOP, x, 1'b0, 1'b1));
            f = fr(d | 8'h80, j ? LAYOUT_PARITY : LAYOUT_1STOP, x);
            f[9] = ~f[9];
            i_asp_far_end.send(f, 10 + j, -1);
            wait_rx();
            cmp(status[2], 1, "framing");
            rd();
        end
        cfg(CFG_FMT_IDX, fmt(LAYOUT_1STOP, 1'b0, 1'b0, 1'b1));
        i_asp_far_end.send(fr(d, LAYOUT_1STOP, 1'b0), 10, -1);
        i_asp_far_end.send(fr(e, LAYOUT_1STOP, 1'b0), 10, -1);
        tick(4);
        cmp({rx_data, status[1:0]}, {d, 2'h3}, "overrun");
        cfg(CFG_CLK_IDX, 8'h44);
        cmp(irq, 1, "irq_overrun");
        rd();
        cmp({irq, status[1:0]}, 0, "overrun_clear");
        cfg(CFG_CLK_IDX, 8'h0c);
        cmp(irq, 1, "irq_tx_done");
        cfg(CFG_CLK_IDX, 8'h14);
        cmp(irq, 1, "irq_tx_empty");
        cfg(CFG_CLK_IDX, 8'h24);
        i_asp_far_end.send(12'h000, 11, -1);
        tick(4);
        cmp({irq, status[6]}, 2'h3, "break");
        rd();
        cmp({irq, status[6]}, 0, "break_clear");
        finish_test();
    end
endmodule
